// >>> vof_formatter.sv
// Contract
// - Header field bit zero field one, one field two
// - Header vertical bit one in vertical blanking
// - Header horizontal bit zero SAV, one EAV
// - Header task bit always one
// - Low four header bits are Hamming protection
// - Embedded header mode words at twice pixel rate
// - Header enable acts only with mux enabled; chroma floats in mux mode
// - Luma 16 to 240, chroma 128 plus/minus 112
// - Each data and sync output tri-stateable by register
// - Output enable pin low floats data outputs
// - Test mode replaces video with generated patterns
// - Helper lines bypass comb filter, processed as luma
// - Helper signal signed on luma port only
// - Core lines carry composite input as luma
// - Core picture uses raw converter amplitudes
// - Helper window lines output demodulated helper
// - Reference lines split signalling and reference parts
// - Syncs resampled on line-locked clock
// - Output timing lags input by three lines
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
module vof_formatter (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // AXI4-Lite register slave
    input wire logic [vof_pkg::AXI_AW-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [vof_pkg::AXI_AW-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // Pins from outside the clock domain
    input wire logic llc_in,
    input wire logic data_output_enable_pin_in,
    input wire logic hsync_in,
    input wire logic vsync_in,
    input wire logic field_in,
    input wire logic vblank_in,
    input wire logic active_in,
    // Video samples from the processing chain
    input wire logic [7:0] y_in,
    input wire logic [7:0] c_in,
    input wire logic [7:0] helper_in,
    input wire logic [7:0] cvbs_raw_in,
    // Output pins with enables, except the comb bypass output, which has none
    output logic [7:0] luma_out,
    output logic luma_oe_out,
    output logic [7:0] chroma_out,
    output logic chroma_oe_out,
    output logic hsync_out,
    output logic hsync_oe_out,
    output logic vsync_out,
    output logic vsync_oe_out,
    output logic active_pixel_marker_out,
    output logic active_pixel_marker_oe_out,
    output logic comb_bypass_out
);
    import vof_pkg::*;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic in_rng(input logic [9:0] v, input logic [9:0] lo,
                                    input logic [9:0] hi);
        return (v >= lo) && (v <= hi);
    endfunction

    function automatic logic [7:0] clip8(input logic [7:0] v, input logic [7:0] lo,
                                         input logic [7:0] hi);
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    function automatic logic [7:0] hdr_status(input logic f, input logic v, input logic h);
        return {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [6:0] sync1_q;
    logic [6:0] sync2_q;
    logic llc3_q;
    logic llc_s, pin_s, hs_s, vs_s, fld_s, vb_s, act_s;

    // Stage one feeds stage two only
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            sync1_q <= 7'h00;
            sync2_q <= 7'h00;
            llc3_q <= 1'b0;
        end else begin
            sync1_q <= {llc_in, data_output_enable_pin_in, hsync_in, vsync_in,
                        field_in, vblank_in, active_in};
            sync2_q <= sync1_q;
            llc3_q <= sync2_q[6];
        end
    end
    assign {llc_s, pin_s, hs_s, vs_s, fld_s, vb_s, act_s} = sync2_q;

    // Pixel on rising link edge, word on either edge
    logic pix_en, word_en;
    assign pix_en = llc_s & ~llc3_q;
    assign word_en = llc_s ^ llc3_q;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [5:0] ctrl_q;
    logic [4:0] oe_q;
    logic mux, ehdr, test, hm;
    vof_pat_e pat;
    assign mux = ctrl_q[CTRL_MUX];
    assign ehdr = ctrl_q[CTRL_EHDR] & mux;
    assign test = ctrl_q[CTRL_TEST];
    assign hm = ctrl_q[CTRL_HLP];
    assign pat = vof_pat_e'(ctrl_q[CTRL_PAT+:2]);

    // ------------------------------------------------------------
    // Line timing, delayed by three lines
    // ------------------------------------------------------------
    logic hs_q;
    logic [2:0] vs_dly_q, fld_dly_q, vb_dly_q;
    logic [9:0] line_q, pix_q;
    logic hs_rise;
    assign hs_rise = pix_en & hs_s & ~hs_q;

    // Vertical signals step one line per sync so they match the comb delay
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            hs_q <= 1'b0;
            vs_dly_q <= 3'h0;
            fld_dly_q <= 3'h0;
            vb_dly_q <= 3'h0;
            line_q <= LN_F1;
            pix_q <= 10'h000;
        end else if (pix_en) begin
            hs_q <= hs_s;
            pix_q <= hs_rise ? 10'h000 : pix_q + 10'h001;
            if (hs_rise) begin
                vs_dly_q <= {vs_dly_q[1:0], vs_s};
                fld_dly_q <= {fld_dly_q[1:0], fld_s};
                vb_dly_q <= {vb_dly_q[1:0], vb_s};
                if (vs_dly_q[1] & ~vs_dly_q[2]) begin
                    line_q <= fld_dly_q[1] ? LN_F2 : LN_F1;
                end else begin
                    line_q <= line_q + 10'h001;
                end
            end
        end
    end

    logic core_l, hwin_l, ref_l, wss_p;
    assign core_l = in_rng(line_q, LN_CORE1_LO, LN_CORE1_HI)
                  | in_rng(line_q, LN_CORE2_LO, LN_CORE2_HI);
    assign hwin_l = in_rng(line_q, LN_HW1_LO, LN_HW1_HI)
                  | in_rng(line_q, LN_HW2_LO, LN_HW2_HI)
                  | in_rng(line_q, LN_HW3_LO, LN_HW3_HI)
                  | in_rng(line_q, LN_HW4_LO, LN_HW4_HI);
    assign ref_l = (line_q == LN_REF1) | (line_q == LN_REF2);
    assign wss_p = pix_q <= WSS_LAST_PIX;

    // ------------------------------------------------------------
    // Sample selection
    // ------------------------------------------------------------
    logic [2:0] bar;
    logic [7:0] y_tp, c_tp, y_hlp, y_sel, c_sel;
    assign bar = pix_q[9:7];

    // Pattern generator; ramps run the full code range on purpose
    always_comb begin
        unique case (pat)
            VOF_PAT_YRAMP: begin
                y_tp = pix_q[7:0];
                c_tp = C_ZERO;
            end
            VOF_PAT_CRAMP: begin
                y_tp = FLAT_Y;
                c_tp = pix_q[7:0];
            end
            VOF_PAT_FLAT: begin
                y_tp = FLAT_Y;
                c_tp = C_ZERO;
            end
            VOF_PAT_BAR: begin
                y_tp = BAR_Y_TOP - 8'({5'h00, bar} * BAR_Y_STEP);
                c_tp = (pix_q[0] ? bar[1] : bar[0]) ? BAR_C_LO : BAR_C_HI;
            end
        endcase
    end

    // Reference lines: signalling part raw, reference part offset binary
    assign y_hlp = wss_p ? cvbs_raw_in : helper_in + C_ZERO;

    // Priority: test, blanking, helper windows, standard
    assign y_sel = test ? y_tp :
                   ~act_s ? Y_MIN :
                   (hm & core_l) ? cvbs_raw_in :
                   (hm & hwin_l) ? helper_in :
                   (hm & ref_l) ? y_hlp :
                   clip8(y_in, Y_MIN, Y_MAX);
    // Helper never appears on chroma; chroma sits at its zero code there
    assign c_sel = test ? c_tp :
                   ~act_s ? C_ZERO :
                   (hm & (hwin_l | ref_l)) ? C_ZERO :
                   clip8(c_in, C_MIN, C_MAX);

    // Two-pixel delay leaves room to insert the start header in blanking
    logic [7:0] y1_q, c1_q, y2_q, c2_q;
    logic a1_q, a2_q;
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            y1_q <= Y_MIN;
            c1_q <= C_ZERO;
            y2_q <= Y_MIN;
            c2_q <= C_ZERO;
            a1_q <= 1'b0;
            a2_q <= 1'b0;
        end else if (pix_en) begin
            y1_q <= y_sel;
            c1_q <= c_sel;
            a1_q <= act_s;
            y2_q <= y1_q;
            c2_q <= c1_q;
            a2_q <= a1_q;
        end
    end

    // ------------------------------------------------------------
    // Embedded headers
    // ------------------------------------------------------------
    logic hdr_on_q, hdr_h_q, hdr_last_q;
    logic [1:0] hdr_cnt_q;
    logic sav, eav, hdr_go, hdr_act;
    logic [1:0] hdr_idx;
    logic [7:0] hdr_word, luma_d;
    assign sav = act_s & ~a1_q;
    assign eav = a2_q & ~a1_q;
    assign hdr_go = ehdr & pix_en & (sav | eav);
    assign hdr_act = hdr_go | hdr_on_q;
    assign hdr_idx = hdr_go ? 2'd0 : hdr_cnt_q;
    assign hdr_word = (hdr_idx == 2'd0) ? HDR_PRE :
                      (hdr_idx == 2'd3) ? hdr_status(fld_dly_q[2], vb_dly_q[2],
                                                     hdr_go ? eav : hdr_h_q) :
                      HDR_ZERO;

    // Falling edge carries luma, the next rising edge chroma of the same pixel
    assign luma_d = hdr_act ? hdr_word :
                    (mux & pix_en) ? c2_q : y2_q;

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            hdr_on_q <= 1'b0;
            hdr_h_q <= 1'b0;
            hdr_cnt_q <= 2'd0;
            hdr_last_q <= 1'b0;
        end else begin
            hdr_last_q <= word_en & hdr_act & (hdr_idx == 2'd3);
            if (hdr_go) begin
                hdr_h_q <= eav;
            end
            if (word_en & hdr_act) begin
                hdr_cnt_q <= hdr_idx + 2'd1;
                hdr_on_q <= hdr_idx != 2'd3;
            end
        end
    end

    // ------------------------------------------------------------
    // Output pins
    // ------------------------------------------------------------
    logic luma_upd;
    logic [7:0] lp1_q, lp2_q, lp3_q;
    assign luma_upd = mux ? word_en : pix_en;

    // Data and syncs; sync pins are unused in the embedded format
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            luma_out <= Y_MIN;
            chroma_out <= C_ZERO;
            hsync_out <= 1'b0;
            vsync_out <= 1'b0;
            active_pixel_marker_out <= 1'b0;
            comb_bypass_out <= 1'b0;
            lp1_q <= 8'h00;
            lp2_q <= 8'h00;
            lp3_q <= 8'h00;
        end else begin
            if (luma_upd) begin
                luma_out <= luma_d;
                lp1_q <= luma_out;
                lp2_q <= lp1_q;
                lp3_q <= lp2_q;
            end
            if (pix_en) begin
                chroma_out <= c2_q;
                hsync_out <= hs_s & ~ehdr;
                vsync_out <= vs_dly_q[2] & ~ehdr;
                active_pixel_marker_out <= a2_q & ~ehdr;
                comb_bypass_out <= hm & (hwin_l | ref_l);
            end
        end
    end

    // Enables: the pin float costs the synchroniser latency plus one register cycle
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            luma_oe_out <= 1'b0;
            chroma_oe_out <= 1'b0;
            hsync_oe_out <= 1'b0;
            vsync_oe_out <= 1'b0;
            active_pixel_marker_oe_out <= 1'b0;
        end else begin
            luma_oe_out <= oe_q[OE_LUMA] & pin_s;
            chroma_oe_out <= oe_q[OE_CHROMA] & pin_s & ~mux;
            hsync_oe_out <= oe_q[OE_HSYNC];
            vsync_oe_out <= oe_q[OE_VSYNC];
            active_pixel_marker_oe_out <= oe_q[OE_MARK];
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    logic aw_got_q, w_got_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic wstrb0_q;
    logic aw_hs, w_hs, have_aw, have_w, do_wr, ar_hs;
    logic aw_got_d, w_got_d, bvalid_d, rvalid_d;
    logic [7:0] wa;
    logic [31:0] wd, rd;
    logic ws0;
    assign aw_hs = s_axi_awvalid_in & s_axi_awready_out;
    assign w_hs = s_axi_wvalid_in & s_axi_wready_out;
    assign have_aw = aw_got_q | aw_hs;
    assign have_w = w_got_q | w_hs;
    assign do_wr = have_aw & have_w;
    assign wa = aw_got_q ? awaddr_q : s_axi_awaddr_in;
    assign wd = w_got_q ? wdata_q : s_axi_wdata_in;
    assign ws0 = w_got_q ? wstrb0_q : s_axi_wstrb_in[0];
    assign aw_got_d = have_aw & ~do_wr;
    assign w_got_d = have_w & ~do_wr;
    assign bvalid_d = do_wr | (s_axi_bvalid_out & ~s_axi_bready_in);
    assign ar_hs = s_axi_arvalid_in & s_axi_arready_out;
    assign rvalid_d = ar_hs | (s_axi_rvalid_out & ~s_axi_rready_in);
    assign rd = (s_axi_araddr_in == REG_CTRL) ? {26'h0, ctrl_q} :
                (s_axi_araddr_in == REG_OE) ? {27'h0, oe_q} :
                {13'h0, pin_s, vb_dly_q[2], fld_dly_q[2], 6'h0, line_q};

    // Address and data may arrive in either order
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb0_q <= 1'b0;
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out <= 1'b1;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= RESP_OKAY;
            ctrl_q <= CTRL_RST;
            oe_q <= OE_RST;
        end else begin
            aw_got_q <= aw_got_d;
            w_got_q <= w_got_d;
            s_axi_awready_out <= ~aw_got_d & ~bvalid_d;
            s_axi_wready_out <= ~w_got_d & ~bvalid_d;
            s_axi_bvalid_out <= bvalid_d;
            if (aw_hs) begin
                awaddr_q <= s_axi_awaddr_in;
            end
            if (w_hs) begin
                wdata_q <= s_axi_wdata_in;
                wstrb0_q <= s_axi_wstrb_in[0];
            end
            if (do_wr) begin
                s_axi_bresp_out <= (wa == REG_CTRL || wa == REG_OE || wa == REG_STAT)
                                   ? RESP_OKAY : RESP_SLVERR;
                if (ws0 && wa == REG_CTRL) begin
                    ctrl_q <= wd[5:0];
                end
                if (ws0 && wa == REG_OE) begin
                    oe_q <= wd[4:0];
                end
            end
        end
    end

    // Read answers one cycle after the address is taken
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            s_axi_arready_out <= 1'b1;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h0000_0000;
            s_axi_rresp_out <= RESP_OKAY;
        end else begin
            s_axi_arready_out <= ~rvalid_d;
            s_axi_rvalid_out <= rvalid_d;
            if (ar_hs) begin
                s_axi_rdata_out <= (s_axi_araddr_in <= REG_STAT) && (s_axi_araddr_in[1:0] == 2'b00)
                                   ? rd : 32'h0000_0000;
                s_axi_rresp_out <= (s_axi_araddr_in <= REG_STAT)
                                   && (s_axi_araddr_in[1:0] == 2'b00) ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    chk_hdr_field: assert property (hdr_last_q |-> luma_out[6] == fld_dly_q[2])
        else $error("header field bit wrong");
    chk_hdr_vert: assert property (hdr_last_q |-> luma_out[5] == vb_dly_q[2])
        else $error("header vertical bit wrong");
    chk_hdr_horiz: assert property (hdr_last_q |-> luma_out[4] == ~a1_q)
        else $error("header horizontal bit wrong");
    chk_hdr_task: assert property (hdr_last_q |-> luma_out[7])
        else $error("header task bit low");
    chk_hdr_parity: assert property (hdr_last_q |-> luma_out[3:0] ==
        {luma_out[5] ^ luma_out[4], luma_out[6] ^ luma_out[4], luma_out[6] ^ luma_out[5],
         luma_out[6] ^ luma_out[5] ^ luma_out[4]})
        else $error("header protection bits wrong");
    chk_hdr_pre: assert property (hdr_last_q |->
        lp3_q == HDR_PRE && lp2_q == HDR_ZERO && lp1_q == HDR_ZERO)
        else $error("header preamble wrong");
    chk_chroma_float: assert property (mux |=> ~chroma_oe_out)
        else $error("chroma driven in multiplexed mode");
    chk_pin_float: assert property (~pin_s |=> ~luma_oe_out && ~chroma_oe_out)
        else $error("data driven with pin deasserted");
    chk_luma_range: assert property (~test & ~hm |-> y_sel >= Y_MIN && y_sel <= Y_MAX)
        else $error("luma code out of range");
    chk_sync_resample: assert property ($changed(hsync_out) |-> $past(pix_en))
        else $error("hsync changed off the link edge");

endmodule

// >>> vof_formatter_bench.sv
module vof_formatter_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import vof_pkg::*;
    logic clk_sys_in = 0, rst_in = 1, llc_in = 0, data_output_enable_pin_in = 1;
    logic hsync_in = 0, vsync_in = 0, field_in = 0, vblank_in = 0, active_in = 0;
    logic [7:0] y_in = 8'h80, c_in = 8'h80, helper_in = 8'h00, cvbs_raw_in = 8'h40;
    logic [7:0] s_axi_awaddr_in = '0, s_axi_araddr_in = '0, luma_out, chroma_out, sav, eav;
    logic [31:0] s_axi_wdata_in = '0, s_axi_rdata_out;
    logic [3:0] s_axi_wstrb_in = '0;
    logic s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_bready_in = 0;
    logic s_axi_arvalid_in = 0, s_axi_rready_in = 0, s_axi_rvalid_out, s_axi_bvalid_out;
    logic s_axi_awready_out, s_axi_wready_out, s_axi_arready_out;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
    logic luma_oe_out, chroma_oe_out, hsync_out, hsync_oe_out, vsync_out, vsync_oe_out;
    logic active_pixel_marker_out, active_pixel_marker_oe_out, comb_bypass_out;
    int errors = 0, comparisons = 0;

    // System clock and a free, unrelated link clock
    always #20 clk_sys_in = ~clk_sys_in;
    always #160 llc_in = ~llc_in;

    vof_formatter uut (.*);
    vof_partner far (.clk_sys_in(clk_sys_in), .luma_in(luma_out), .sav_out(sav), .eav_out(eav));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    function automatic logic [31:0] oe();
        return 32'({active_pixel_marker_oe_out, vsync_oe_out, hsync_oe_out,
                    chroma_oe_out, luma_oe_out});
    endfunction

    // Write: both halves offered at once, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        bit ta = 0;
        bit tw = 0;
        // Let an edge pass so bready is never dropped and raised in one step
        @(posedge clk_sys_in);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        s_axi_wstrb_in <= 4'hF;
        s_axi_awvalid_in <= 1;
        s_axi_wvalid_in <= 1;
        s_axi_bready_in <= 1;
        while (!(ta && tw)) begin
            @(posedge clk_sys_in);
            if (s_axi_awready_out === 1'b1) begin
                ta = 1;
                s_axi_awvalid_in <= 0;
            end
            if (s_axi_wready_out === 1'b1) begin
                tw = 1;
                s_axi_wvalid_in <= 0;
            end
        end
        do @(posedge clk_sys_in); while (s_axi_bvalid_out !== 1'b1);
        chk("bresp", 32'(er), 32'(s_axi_bresp_out));
        s_axi_bready_in <= 0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge clk_sys_in);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1;
        s_axi_rready_in <= 1;
        do @(posedge clk_sys_in); while (s_axi_arready_out !== 1'b1);
        s_axi_arvalid_in <= 0;
        do @(posedge clk_sys_in); while (s_axi_rvalid_out !== 1'b1);
        chk("rdata", e, s_axi_rdata_out);
        chk("rresp", 32'(er), 32'(s_axi_rresp_out));
        s_axi_rready_in <= 0;
    endtask

    task automatic px(input int n);
        repeat (n) @(posedge llc_in);
        // Cover the synchroniser and edge-detect lag of the last pixel
        repeat (4) @(posedge clk_sys_in);
    endtask

    // One short line: sync pulse, blanking, eight active pixels
    task automatic line(input logic f, input logic v);
        field_in <= f;
        vblank_in <= v;
        hsync_in <= 1;
        px(2);
        hsync_in <= 0;
        px(4);
        active_in <= 1;
        px(8);
        active_in <= 0;
        px(6);
    endtask

    task automatic print_verdict;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk_sys_in);
        rst_in <= 0;
        @(posedge clk_sys_in);
        rd(REG_CTRL, 32'h0000_0000, RESP_OKAY);
        rd(REG_OE, 32'h0000_001F, RESP_OKAY);
        rd(8'h0C, 32'h0000_0000, RESP_SLVERR);
        wr(8'h10, 32'h0000_0000, RESP_SLVERR);
        wr(REG_STAT, 32'h0000_0000, RESP_OKAY);
        for (int i = 0; i < 6; i++) begin
            wr(REG_OE, 32'h1F >> i, RESP_OKAY);
            repeat (3) @(posedge clk_sys_in);
            chk("oe", 32'h1F >> i, oe());
        end
        wr(REG_OE, 32'h0000_001F, RESP_OKAY);
        data_output_enable_pin_in <= 0;
        repeat (4) @(posedge clk_sys_in);
        chk("oe", 32'h0000_001C, oe());
        data_output_enable_pin_in <= 1;
        active_in <= 1;
        y_in <= 8'hFF;
        c_in <= 8'h00;
        px(4);
        chk("oe", 32'h0000_001F, oe());
        chk("luma", 32'(Y_MAX), 32'(luma_out));
        chk("chroma", 32'(C_MIN), 32'(chroma_out));
        y_in <= 8'h80;
        c_in <= 8'h80;
        active_in <= 0;
        for (int p = 0; p < 4; p++) begin
            wr(REG_CTRL, 32'(p * 8 + 4), RESP_OKAY);
            px(4);
            if (p == 2) chk("flat", 32'(FLAT_Y), 32'(luma_out));
        end
        wr(REG_CTRL, 32'h0000_0001, RESP_OKAY);
        repeat (3) @(posedge clk_sys_in);
        chk("oe", 32'h0000_001D, oe());
        wr(REG_CTRL, 32'h0000_0003, RESP_OKAY);
        repeat (5) line(0, 0);
        chk("sav", 32'h80, 32'(sav));
        chk("eav", 32'h9D, 32'(eav));
        chk("hsync", 32'h0, 32'(hsync_out));
        chk("vsync", 32'h0, 32'(vsync_out));
        chk("marker", 32'h0, 32'(active_pixel_marker_out));
        repeat (5) line(1, 1);
        chk("sav", 32'hEC, 32'(sav));
        chk("eav", 32'hF1, 32'(eav));
        print_verdict();
    end

    // Watchdog well beyond the expected run of about 1830 cycles
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        errors++;
        print_verdict();
    end
endmodule

// >>> vof_partner.sv
module vof_partner (
    // Watched pins
    input wire logic clk_sys_in,
    input wire logic [7:0] luma_in,
    // Last status words
    output logic [7:0] sav_out,
    output logic [7:0] eav_out
);
    import vof_pkg::*;
    int zeros = 0;
    bit armed = 0;
    // Hunt headers by run length, since the word phase is unknown
    always @(posedge clk_sys_in) begin
        if (luma_in === HDR_PRE) begin
            armed = 1;
            zeros = 0;
        end else if (armed && luma_in === HDR_ZERO) begin
            zeros++;
        end else if (armed) begin
            armed = 0;
            if (zeros > 4 && luma_in[4]) eav_out = luma_in;
            else if (zeros > 4) sav_out = luma_in;
        end
    end
endmodule

// >>> vof_pkg.sv
package vof_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int AXI_AW = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_OE = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h08;
    localparam logic [5:0] CTRL_RST = 6'h00;
    localparam logic [4:0] OE_RST = 5'h1F;
    localparam int CTRL_MUX = 0;
    localparam int CTRL_EHDR = 1;
    localparam int CTRL_TEST = 2;
    localparam int CTRL_PAT = 3;
    localparam int CTRL_HLP = 5;
    localparam int OE_LUMA = 0;
    localparam int OE_CHROMA = 1;
    localparam int OE_HSYNC = 2;
    localparam int OE_VSYNC = 3;
    localparam int OE_MARK = 4;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ------------------------------------------------------------
    // Code levels and header words
    // ------------------------------------------------------------
    localparam logic [7:0] Y_MIN = 8'h10;
    localparam logic [7:0] Y_MAX = 8'hF0;
    localparam logic [7:0] C_MIN = 8'h10;
    localparam logic [7:0] C_MAX = 8'hF0;
    localparam logic [7:0] C_ZERO = 8'h80;
    localparam logic [7:0] HDR_PRE = 8'hFF;
    localparam logic [7:0] HDR_ZERO = 8'h00;

    // ------------------------------------------------------------
    // Test patterns
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        VOF_PAT_YRAMP,
        VOF_PAT_CRAMP,
        VOF_PAT_FLAT,
        VOF_PAT_BAR
    } vof_pat_e;
    localparam logic [7:0] FLAT_Y = 8'hB4;
    localparam logic [7:0] BAR_Y_TOP = 8'hEB;
    localparam logic [7:0] BAR_Y_STEP = 8'h1C;
    localparam logic [7:0] BAR_C_LO = 8'h30;
    localparam logic [7:0] BAR_C_HI = 8'hD0;

    // ------------------------------------------------------------
    // Line windows of the wide-screen helper mode
    // ------------------------------------------------------------
    localparam logic [9:0] LN_F1 = 10'd1;
    localparam logic [9:0] LN_F2 = 10'd313;
    localparam logic [9:0] LN_CORE1_LO = 10'd60;
    localparam logic [9:0] LN_CORE1_HI = 10'd274;
    localparam logic [9:0] LN_CORE2_LO = 10'd372;
    localparam logic [9:0] LN_CORE2_HI = 10'd586;
    localparam logic [9:0] LN_HW1_LO = 10'd24;
    localparam logic [9:0] LN_HW1_HI = 10'd59;
    localparam logic [9:0] LN_HW2_LO = 10'd275;
    localparam logic [9:0] LN_HW2_HI = 10'd310;
    localparam logic [9:0] LN_HW3_LO = 10'd336;
    localparam logic [9:0] LN_HW3_HI = 10'd371;
    localparam logic [9:0] LN_HW4_LO = 10'd587;
    localparam logic [9:0] LN_HW4_HI = 10'd622;
    localparam logic [9:0] LN_REF1 = 10'd23;
    localparam logic [9:0] LN_REF2 = 10'd623;
    localparam logic [9:0] WSS_LAST_PIX = 10'd300;

endpackage
